// *** rtl/hs_homing_seq.sv ***
// homing sequencer: switch and index based return-to-zero methods
`timescale 1ns/1ps
module hs_homing_seq
  import hs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                start,
  input  wire logic                halt,
  input  wire logic [METHOD_W-1:0] method,
  input  wire hs_sw_t              sw_in,
  input  wire logic [POS_W-1:0]    enc_pos,
  output hs_speed_t                speed,
  output logic                     dir_fwd,
  output logic                     zero_cap,
  output logic [POS_W-1:0]         home_pos,
  output logic                     busy,
  output logic                     done,
  output logic                     method_err
);

  hs_sw_t  lvl;
  hs_sw_t  rise;
  hs_sw_t  fall;
  hs_ctl_t q;
  hs_ctl_t d;

  hs_sw_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (sw_in),
    .lvl     (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  function automatic hs_plan_t mk(hs_state_t st0, logic fhi, logic dir0, hs_edge_t decel,
                                  logic sdir, hs_edge_t arm, logic use_idx, hs_edge_t lim);
    hs_plan_t p;
    p = '{st0, fhi, dir0, decel, sdir, arm, use_idx, lim};
    return p;
  endfunction

  function automatic logic method_ok(logic [METHOD_W-1:0] m);
    logic ok;
    ok = 1'b0;
    case (m)
      M_HOME_IDX_A, M_HOME_IDX_B, M_REV_OT, M_FWD_OT, M_HOME_A,
      M_HOME_B, M_HOME_C, M_HOME_D, M_HOME_E: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // lim set picks the branch taken once the travel limit was hit
  function automatic hs_plan_t plan_f(logic [METHOD_W-1:0] m, logic l, logic lim);
    hs_plan_t r;
    r = mk(ST_IDLE, 1'b0, DIR_REV, EG_NONE, DIR_REV, EG_NONE, 1'b0, EG_NONE);
    case (m)
      M_HOME_IDX_A: begin
        if (lim) begin
          r = mk(ST_SLOW, 1'b0, DIR_FWD, EG_NONE, DIR_FWD, EG_HOME_R, 1'b1, EG_NONE);
        end else if (l) begin
          r = mk(ST_FAST, 1'b0, DIR_REV, EG_HOME_F, DIR_FWD, EG_HOME_R, 1'b1, EG_NONE);
        end else begin
          r = mk(ST_FAST, 1'b1, DIR_REV, EG_HOME_R, DIR_REV, EG_NONE, 1'b1, EG_RLIM_R);
        end
      end
      M_HOME_IDX_B: begin
        if (lim) begin
          r = mk(ST_FAST, 1'b1, DIR_FWD, EG_HOME_R, DIR_REV, EG_NONE, 1'b1, EG_NONE);
        end else if (l) begin
          r = mk(ST_SLOW, 1'b0, DIR_REV, EG_NONE, DIR_REV, EG_HOME_F, 1'b1, EG_NONE);
        end else begin
          r = mk(ST_FAST, 1'b1, DIR_REV, EG_HOME_R, DIR_REV, EG_HOME_F, 1'b1, EG_RLIM_R);
        end
      end
      M_REV_OT: begin
        if (l) begin
          r = mk(ST_SLOW, 1'b0, DIR_FWD, EG_NONE, DIR_FWD, EG_RLIM_F, 1'b0, EG_NONE);
        end else begin
          r = mk(ST_FAST, 1'b1, DIR_REV, EG_RLIM_R, DIR_FWD, EG_RLIM_F, 1'b0, EG_NONE);
        end
      end
      M_FWD_OT: begin
        if (l) begin
          r = mk(ST_SLOW, 1'b0, DIR_REV, EG_NONE, DIR_REV, EG_FLIM_F, 1'b0, EG_NONE);
        end else begin
          r = mk(ST_FAST, 1'b1, DIR_FWD, EG_FLIM_R, DIR_REV, EG_FLIM_F, 1'b0, EG_NONE);
        end
      end
      M_HOME_A: begin
        if (l) begin
          r = mk(ST_SLOW, 1'b0, DIR_REV, EG_NONE, DIR_REV, EG_HOME_F, 1'b0, EG_NONE);
        end else begin
          r = mk(ST_FAST, 1'b1, DIR_FWD, EG_HOME_R, DIR_REV, EG_HOME_F, 1'b0, EG_NONE);
        end
      end
      M_HOME_B: begin
        if (l) begin
          r = mk(ST_FAST, 1'b1, DIR_REV, EG_HOME_F, DIR_FWD, EG_HOME_R, 1'b0, EG_NONE);
        end else begin
          // direction not given for this branch: forward chosen
          r = mk(ST_SLOW, 1'b0, DIR_FWD, EG_NONE, DIR_FWD, EG_HOME_R, 1'b0, EG_NONE);
        end
      end
      M_HOME_C: begin
        if (l) begin
          r = mk(ST_SLOW, 1'b0, DIR_FWD, EG_NONE, DIR_FWD, EG_HOME_F, 1'b0, EG_NONE);
        end else begin
          r = mk(ST_FAST, 1'b1, DIR_REV, EG_HOME_R, DIR_FWD, EG_HOME_F, 1'b0, EG_NONE);
        end
      end
      M_HOME_D: begin
        if (l) begin
          r = mk(ST_FAST, 1'b1, DIR_FWD, EG_HOME_F, DIR_REV, EG_HOME_R, 1'b0, EG_NONE);
        end else begin
          r = mk(ST_SLOW, 1'b0, DIR_REV, EG_NONE, DIR_REV, EG_HOME_R, 1'b0, EG_NONE);
        end
      end
      M_HOME_E: begin
        if (lim) begin
          r = mk(ST_FAST, 1'b1, DIR_REV, EG_HOME_R, DIR_REV, EG_HOME_F, 1'b0, EG_NONE);
        end else if (l) begin
          r = mk(ST_SLOW, 1'b0, DIR_REV, EG_NONE, DIR_REV, EG_HOME_F, 1'b0, EG_NONE);
        end else begin
          r = mk(ST_FAST, 1'b1, DIR_FWD, EG_HOME_R, DIR_REV, EG_HOME_F, 1'b0, EG_FLIM_R);
        end
      end
      default: r = mk(ST_IDLE, 1'b0, DIR_REV, EG_NONE, DIR_REV, EG_NONE, 1'b0, EG_NONE);
    endcase
    return r;
  endfunction

  function automatic logic edge_hit(hs_edge_t e, hs_sw_t r, hs_sw_t f);
    logic h;
    h = 1'b0;
    case (e)
      EG_HOME_R: h = r.home;
      EG_HOME_F: h = f.home;
      EG_RLIM_R: h = r.rlim;
      EG_RLIM_F: h = f.rlim;
      EG_FLIM_R: h = r.flim;
      EG_FLIM_F: h = f.flim;
      default:   h = 1'b0;
    endcase
    return h;
  endfunction

  // overtravel methods look at their own switch, the rest at home
  logic start_lvl;
  always_comb begin
    case (method)
      M_REV_OT: start_lvl = lvl.rlim;
      M_FWD_OT: start_lvl = lvl.flim;
      default:  start_lvl = lvl.home;
    endcase
  end

  always_comb begin
    logic     ld;
    logic     fin;
    hs_plan_t p;
    ld    = 1'b0;
    fin   = 1'b0;
    p     = q.pl;
    d     = q;
    d.cap = 1'b0;
    case (q.st)
      ST_IDLE, ST_DONE: begin
        if (start) begin
          if (method_ok(method)) begin
            ld     = 1'b1;
            p      = plan_f(method, start_lvl, 1'b0);
            d.meth = method;
            d.busy = 1'b1;
            d.done = 1'b0;
            d.err  = 1'b0;
          end else begin
            d.err  = 1'b1;
          end
        end
      end
      ST_FAST: begin
        // a travel limit outranks the deceleration edge in the same cycle
        if (edge_hit(q.pl.lim, rise, fall)) begin
          ld = 1'b1;
          p  = plan_f(q.meth, 1'b0, 1'b1);
        end else if (edge_hit(q.pl.decel, rise, fall)) begin
          d.dir = q.pl.sdir;
          d.spd = SPD_LOW;
          d.st  = (q.pl.arm == EG_NONE) ? ST_IDX : ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (edge_hit(q.pl.arm, rise, fall)) begin
          if (q.pl.use_idx) begin
            d.st = ST_IDX;
          end else begin
            fin = 1'b1;
          end
        end
      end
      ST_IDX: begin
        if (rise.idx) begin
          fin = 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    if (ld) begin
      d.pl = p;
      if (p.st0 == ST_FAST) begin
        d.st  = ST_FAST;
        d.dir = p.dir0;
        d.spd = p.fhi ? SPD_HIGH : SPD_LOW;
      end else begin
        d.st  = ST_SLOW;
        d.dir = p.sdir;
        d.spd = SPD_LOW;
      end
    end
    if (fin) begin
      d.st   = ST_DONE;
      d.spd  = SPD_STOP;
      d.cap  = 1'b1;
      d.busy = 1'b0;
      d.done = 1'b1;
    end
    // halt drops the run without a zero point
    if (halt && q.busy) begin
      d.st   = ST_IDLE;
      d.spd  = SPD_STOP;
      d.busy = 1'b0;
      d.cap  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{ST_IDLE, '0, RST_METHOD, SPD_STOP, DIR_REV, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      q <= d;
    end
  end

  hs_pos_latch u_lat (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cap     (d.cap),
    .pos     (enc_pos),
    .pos_q   (home_pos)
  );

  assign speed      = q.spd;
  assign dir_fwd    = q.dir;
  assign zero_cap   = q.cap;
  assign busy       = q.busy;
  assign done       = q.done;
  assign method_err = q.err;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_go(logic [METHOD_W-1:0] m, logic l);
    start && !halt && !q.busy && method == m && start_lvl == l;
  endsequence

  a_cap_stops: assert property (zero_cap |-> speed == SPD_STOP && done && !busy)
    else $error("zero capture without stop and done");
  a_cap_position: assert property (zero_cap |-> home_pos == $past(enc_pos))
    else $error("captured position differs from encoder");
  a_bad_method: assert property (start && !q.busy && !method_ok(method)
    |=> method_err && !busy)
    else $error("unknown method not refused");
  a_m20_low_start: assert property (s_go(M_HOME_B, 1'b0) |=> speed == SPD_LOW && dir_fwd)
    else $error("method 20 low start wrong");
  a_m19_fast_start: assert property (s_go(M_HOME_A, 1'b0)
    |=> speed == SPD_HIGH && dir_fwd)
    else $error("method 19 fast start wrong");
  a_m14_direct: assert property (s_go(M_HOME_IDX_B, 1'b1) |=> speed == SPD_LOW && !dir_fwd)
    else $error("method 14 direct start wrong");
  a_m17_turn: assert property (q.st == ST_FAST && q.meth == M_REV_OT && rise.rlim && !halt
    |=> speed == SPD_LOW && dir_fwd && q.st == ST_SLOW)
    else $error("method 17 did not turn forward slow");
  a_idx_capture: assert property (q.st == ST_IDX && rise.idx && !halt
    |=> zero_cap ##1 !zero_cap)
    else $error("index pulse did not capture once");

endmodule

// *** rtl/hs_pkg.sv ***
// shared types and constants of the homing sequencer
package hs_pkg;

  localparam int unsigned METHOD_W = 8;
  localparam int unsigned POS_W    = 32;

  localparam logic [METHOD_W-1:0] M_HOME_IDX_A = 8'h0D;
  localparam logic [METHOD_W-1:0] M_HOME_IDX_B = 8'h0E;
  localparam logic [METHOD_W-1:0] M_REV_OT     = 8'h11;
  localparam logic [METHOD_W-1:0] M_FWD_OT     = 8'h12;
  localparam logic [METHOD_W-1:0] M_HOME_A     = 8'h13;
  localparam logic [METHOD_W-1:0] M_HOME_B     = 8'h14;
  localparam logic [METHOD_W-1:0] M_HOME_C     = 8'h15;
  localparam logic [METHOD_W-1:0] M_HOME_D     = 8'h16;
  localparam logic [METHOD_W-1:0] M_HOME_E     = 8'h17;

  localparam logic DIR_FWD = 1'b1;
  localparam logic DIR_REV = 1'b0;

  localparam logic [POS_W-1:0]    RST_POS    = 32'h0000_0000;
  localparam logic [METHOD_W-1:0] RST_METHOD = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FAST = 3'h1,
    ST_SLOW = 3'h2,
    ST_IDX  = 3'h3,
    ST_DONE = 3'h4
  } hs_state_t;

  typedef enum logic [1:0] {
    SPD_STOP = 2'h0,
    SPD_LOW  = 2'h1,
    SPD_HIGH = 2'h2
  } hs_speed_t;

  typedef enum logic [2:0] {
    EG_NONE   = 3'h0,
    EG_HOME_R = 3'h1,
    EG_HOME_F = 3'h2,
    EG_RLIM_R = 3'h3,
    EG_RLIM_F = 3'h4,
    EG_FLIM_R = 3'h5,
    EG_FLIM_F = 3'h6
  } hs_edge_t;

  typedef struct packed {
    logic home;
    logic flim;
    logic rlim;
    logic idx;
  } hs_sw_t;

  localparam hs_sw_t RST_SW = 4'h0;

  // one homing branch: first phase, then the slow phase, then optional index
  typedef struct packed {
    hs_state_t st0;
    logic      fhi;
    logic      dir0;
    hs_edge_t  decel;
    logic      sdir;
    hs_edge_t  arm;
    logic      use_idx;
    hs_edge_t  lim;
  } hs_plan_t;

  typedef struct packed {
    hs_state_t           st;
    hs_plan_t            pl;
    logic [METHOD_W-1:0] meth;
    hs_speed_t           spd;
    logic                dir;
    logic                cap;
    logic                busy;
    logic                done;
    logic                err;
  } hs_ctl_t;

endpackage

// *** rtl/hs_pos_latch.sv ***
// holds the encoder position caught at the zero point
`timescale 1ns/1ps
module hs_pos_latch
  import hs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             cap,
  input  wire logic [POS_W-1:0] pos,
  output logic [POS_W-1:0]      pos_q
);

  typedef struct packed {
    logic [POS_W-1:0] held;
  } hs_lat_t;

  hs_lat_t q;
  hs_lat_t d;

  always_comb begin
    d = q;
    if (cap) begin
      d.held = pos;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q.held <= RST_POS;
    end else begin
      q <= d;
    end
  end

  assign pos_q = q.held;

endmodule

// *** rtl/hs_sw_sync.sv ***
// two-stage synchroniser and edge detector for the switch and index inputs
`timescale 1ns/1ps
module hs_sw_sync
  import hs_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire hs_sw_t din,
  output hs_sw_t      lvl,
  output hs_sw_t      rise,
  output hs_sw_t      fall
);

  typedef struct packed {
    hs_sw_t s1;
    hs_sw_t s2;
    hs_sw_t prev;
  } hs_sync_t;

  hs_sync_t q;
  hs_sync_t d;

  always_comb begin
    d      = q;
    d.s1   = din;
    d.s2   = q.s1;
    d.prev = q.s2;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{RST_SW, RST_SW, RST_SW};
    end else begin
      q <= d;
    end
  end

  // edges only from second stage onward
  assign lvl  = q.s2;
  assign rise = q.s2 & ~q.prev;
  assign fall = ~q.s2 & q.prev;

  sequence s_home_up;
    $rose(din.home) ##1 din.home;
  endsequence

  a_home_rise_lag: assert property (@(posedge clk) disable iff (sys_rst)
    s_home_up |=> rise.home)
    else $error("home rise not seen two cycles after input rose");

endmodule

// *** verif/hs_homing_seq_tb_top.sv ***
// self-checking bench for the homing sequencer
`timescale 1ns/1ps
module hs_homing_seq_tb_top
  import hs_pkg::*;
;
  logic                clk      = 1'b0;
  logic                sys_rst  = 1'b1;
  logic                start    = 1'b0;
  logic                halt     = 1'b0;
  logic                load     = 1'b0;
  logic [METHOD_W-1:0] method   = 8'h13;
  logic [POS_W-1:0]    load_pos = 32'h0000_0032;
  logic [POS_W-1:0]    pos;
  logic [POS_W-1:0]    home_pos;
  hs_sw_t              sw;
  hs_speed_t           speed;
  logic                dir_fwd;
  logic                zero_cap;
  logic                busy;
  logic                done;
  logic                method_err;
  int                  fail_count = 0;
  int                  tests_run  = 0;
  // start class: 0 left of cam, 1 right of cam, 2 on cam, 3 on rev stop, 4 on fwd stop
  int sm[21] = '{13, 13, 13, 14, 14, 14, 17, 17, 18, 18, 19,
                 19, 20, 20, 21, 21, 22, 22, 23, 23, 23};
  int sc[21] = '{1, 0, 2, 1, 0, 2, 0, 3, 1, 4, 0, 2, 0, 2, 1, 2, 1, 2, 0, 1, 2};
  int bad[3] = '{0, 15, 24};

  always #12.5 clk = ~clk;

  hs_homing_seq hs_homing_seq_i (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (start),
    .halt       (halt),
    .method     (method),
    .sw_in      (sw),
    .enc_pos    (pos),
    .speed      (speed),
    .dir_fwd    (dir_fwd),
    .zero_cap   (zero_cap),
    .home_pos   (home_pos),
    .busy       (busy),
    .done       (done),
    .method_err (method_err)
  );

  hs_motor_model hs_motor_model_i (
    .clk      (clk),
    .load     (load),
    .load_pos (load_pos),
    .speed    (speed),
    .dir_fwd  (dir_fwd),
    .pos      (pos),
    .sw       (sw)
  );

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_pos(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // switches need the synchroniser depth to settle before start samples them
  task automatic go(input int m, input int p);
    load = 1'b1;
    load_pos = p[POS_W-1:0];
    cyc(1);
    load = 1'b0;
    cyc(4);
    method = m[METHOD_W-1:0];
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(1);
  endtask

  task automatic wait_cap();
    int k;
    for (k = 0; k < 8000 && zero_cap !== 1'b1; k++) cyc(1);
    if (k == 8000) begin
      fail_count++;
      end_sim();
    end
  endtask

  function automatic bit lvl(input int s, input int p);
    case (s)
      0: return p >= 100 && p <= 120;
      1: return p <= 10;
      2: return p >= 300;
      default: return 1'b0;
    endcase
  endfunction

  // edge code: signal times two, plus one for a falling edge; 7 means none
  function automatic bit hit(input int e, input int p, input int q);
    bit a;
    bit b;
    a = lvl(e / 2, p);
    b = lvl(e / 2, q);
    return (e % 2) ? (a && !b) : (!a && b);
  endfunction

  function automatic int pick(input int c);
    case (c)
      0: return 20 + $urandom % 70;
      1: return 150 + $urandom % 100;
      2: return 101 + $urandom % 19;
      3: return $urandom % 11;
      default: return 300 + $urandom % 20;
    endcase
  endfunction

  // plan nibbles: first dir, first edge, slow dir, arm edge
  function automatic int model(input int m, input int p0, output int d0);
    logic [15:0] t;
    logic [15:0] lt;
    int p, q, d, ph, le, k;
    bit ix;
    p = p0;
    le = -1;
    lt = 16'h0000;
    ix = (m == 13) || (m == 14);
    case (m)
      13: begin
        t = lvl(0, p) ? 16'h0110 : 16'h0007;
        le = 2;
        lt = 16'h1710;
      end
      14: begin
        t = lvl(0, p) ? 16'h0701 : 16'h0001;
        le = 2;
        lt = 16'h1007;
      end
      17: t = lvl(1, p) ? 16'h1713 : 16'h0213;
      18: t = lvl(2, p) ? 16'h0705 : 16'h1405;
      19: t = lvl(0, p) ? 16'h0701 : 16'h1001;
      20: t = lvl(0, p) ? 16'h0110 : 16'h1710;
      21: t = lvl(0, p) ? 16'h1711 : 16'h0011;
      22: t = lvl(0, p) ? 16'h1100 : 16'h0700;
      default: begin
        t = lvl(0, p) ? 16'h0701 : 16'h1001;
        le = 4;
        lt = 16'h0001;
      end
    endcase
    ph = (t[11:8] == 4'h7);
    d = ph ? t[7:4] : t[15:12];
    // bit 0 first direction, bit 2 set for a high-speed first phase
    d0 = d + ((ph || (m == 13 && t == 16'h0110)) ? 2 : 4);
    for (k = 0; k < 4000; k++) begin
      if (ph == 1 && t[3:0] == 4'h7) ph = 2;
      q = d ? p + 1 : p - 1;
      if (ph == 0 && le >= 0 && hit(le, p, q)) begin
        t = lt;
        le = -1;
        ph = (t[11:8] == 4'h7);
        d = ph ? t[7:4] : t[15:12];
      end else if (ph == 0 && hit(t[11:8], p, q)) begin
        ph = 1;
        d = t[7:4];
      end else if (ph == 1 && hit(t[3:0], p, q)) begin
        if (!ix) return q;
        ph = 2;
      end else if (ph == 2 && q % 16 == 0) begin
        return q;
      end
      p = q;
    end
    return -1;
  endfunction

  initial begin
    int p, d0, ep, i;
    void'($urandom(32'h1E35ED3C));
    cyc(16);
    sys_rst = 1'b0;
    cyc(1);
    chk_pos(home_pos, RST_POS);
    chk_bit(busy | done | zero_cap | method_err | dir_fwd, 1'b0);
    chk_bit(speed == SPD_STOP, 1'b1);
    cyc(2);
    for (i = 0; i < 21; i++) begin
      p = pick(sc[i]);
      ep = model(sm[i], p, d0);
      go(sm[i], p);
      chk_bit(dir_fwd, d0[0]);
      chk_bit(speed == (d0[2] ? SPD_HIGH : SPD_LOW), 1'b1);
      wait_cap();
      chk_pos(home_pos, ep[POS_W-1:0]);
      chk_bit(done & ~busy & ~method_err, 1'b1);
      chk_bit(speed == SPD_STOP, 1'b1);
      cyc(1);
      chk_bit(zero_cap, 1'b0);
    end
    foreach (bad[j]) begin
      go(bad[j], 50);
      chk_bit(method_err & ~busy, 1'b1);
    end
    go(19, 50);
    cyc(8);
    method = M_REV_OT;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(2);
    chk_bit(dir_fwd, DIR_FWD);
    halt = 1'b1;
    cyc(1);
    halt = 1'b0;
    cyc(2);
    chk_bit(busy | done, 1'b0);
    chk_bit(speed == SPD_STOP, 1'b1);
    end_sim();
  end
endmodule

// *** verif/hs_motor_model.sv ***
// motor, encoder index and switch model driven by the sequencer
`timescale 1ns/1ps
module hs_motor_model
  import hs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             load,
  input  wire logic [POS_W-1:0] load_pos,
  input  wire hs_speed_t        speed,
  input  wire logic             dir_fwd,
  output logic [POS_W-1:0]      pos,
  output hs_sw_t                sw
);
  int cnt = 0;

  initial pos = 32'h0000_0032;

  // high speed steps every 8 cycles so a decel lands before the next step
  always @(posedge clk) begin
    if (load) begin
      pos <= load_pos;
      cnt <= 0;
    end else if (speed == SPD_STOP) begin
      cnt <= 0;
    end else if (cnt >= ((speed == SPD_HIGH) ? 7 : 15)) begin
      pos <= dir_fwd ? pos + 32'h1 : pos - 32'h1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // home cam, both end stops and one index mark every 16 counts
  always_comb begin
    sw.home = (pos >= 32'h64) && (pos <= 32'h78);
    sw.rlim = pos <= 32'hA;
    sw.flim = pos >= 32'h12C;
    sw.idx  = pos[3:0] == 4'h0;
  end
endmodule
